// ==== rtl/spc_pkg.sv ====
package spc_pkg;

	// ---------------------------------------------------------------
	// parameter memory geometry
	// ---------------------------------------------------------------
	localparam int PARAM_DEPTH = 32;
	localparam int PARAM_AW = 5;

	// ---------------------------------------------------------------
	// parameter offsets
	// ---------------------------------------------------------------
	localparam logic [4:0] OFS_BUS_ADDRESS_PARAM = 5'h00;
	localparam logic [4:0] OFS_CHANNEL_ENABLE_LIST = 5'h01;
	localparam logic [4:0] OFS_EMITTER_SELECT_CH12 = 5'h02;
	localparam logic [4:0] OFS_EMITTER_SELECT_CH3 = 5'h03;
	localparam logic [4:0] OFS_PROX1_INPUT_SELECT = 5'h07;
	localparam logic [4:0] OFS_PROX2_INPUT_SELECT = 5'h08;
	localparam logic [4:0] OFS_PROX3_INPUT_SELECT = 5'h09;
	localparam logic [4:0] OFS_PROX_CONV_COUNTER = 5'h0A;
	localparam logic [4:0] OFS_PROX_CONV_GAIN = 5'h0B;
	localparam logic [4:0] OFS_PROX_CONV_MISC = 5'h0C;
	localparam logic [4:0] OFS_RESERVED_PARAM_0D = 5'h0D;
	localparam logic [4:0] OFS_IR_AMBIENT_INPUT_SELECT = 5'h0E;
	localparam logic [4:0] OFS_AUX_INPUT_SELECT = 5'h0F;
	localparam logic [4:0] OFS_VISIBLE_CONV_COUNTER = 5'h10;
	localparam logic [4:0] OFS_VISIBLE_CONV_GAIN = 5'h11;
	localparam logic [4:0] OFS_VISIBLE_CONV_MISC = 5'h12;
	localparam logic [4:0] OFS_RESERVED_PARAM_13 = 5'h13;
	localparam logic [4:0] OFS_RESERVED_PARAM_14 = 5'h14;
	localparam logic [4:0] OFS_RESERVED_PARAM_15 = 5'h15;
	localparam logic [4:0] OFS_RESERVED_PARAM_1B = 5'h1B;
	localparam logic [4:0] OFS_EMITTER_RECOVERY_TIME = 5'h1C;
	localparam logic [4:0] OFS_IR_AMBIENT_CONV_COUNTER = 5'h1D;
	localparam logic [4:0] OFS_IR_AMBIENT_CONV_GAIN = 5'h1E;
	localparam logic [4:0] OFS_IR_AMBIENT_CONV_MISC = 5'h1F;

	// ---------------------------------------------------------------
	// writable bit masks
	// ---------------------------------------------------------------
	localparam logic [7:0] MASK_ALL = 8'hFF;
	localparam logic [7:0] MASK_CHANNEL_ENABLE_LIST = 8'hF7;
	localparam logic [7:0] MASK_EMITTER_SELECT_CH12 = 8'h77;
	localparam logic [7:0] MASK_EMITTER_SELECT_CH3 = 8'h07;
	localparam logic [7:0] MASK_CONV_COUNTER = 8'h70;
	localparam logic [7:0] MASK_CONV_GAIN = 8'h07;
	localparam logic [7:0] MASK_PROX_CONV_MISC = 8'h24;
	localparam logic [7:0] MASK_AMBIENT_CONV_MISC = 8'h20;
	localparam logic [7:0] MASK_READ_ONLY = 8'h00;

	// ---------------------------------------------------------------
	// reset values
	// ---------------------------------------------------------------
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_EMITTER_SELECT_CH12 = 8'h21;
	localparam logic [7:0] RST_EMITTER_SELECT_CH3 = 8'h04;
	localparam logic [7:0] RST_RESERVED_PARAM_0D = 8'h02;
	localparam logic [7:0] RST_RESERVED_PARAM_13 = 8'h40;
	// power-up bus address, value is arbitrary
	localparam logic [7:0] RST_ACTIVE_BUS_ADDRESS = 8'h5A;

	// ---------------------------------------------------------------
	// channel list bit positions
	// ---------------------------------------------------------------
	localparam int BIT_PROX_CHANNEL1_ENABLE = 0;
	localparam int BIT_PROX_CHANNEL2_ENABLE = 1;
	localparam int BIT_PROX_CHANNEL3_ENABLE = 2;
	localparam int BIT_CHANNEL_RESERVED = 3;
	localparam int BIT_VISIBLE_AMBIENT_ENABLE = 4;
	localparam int BIT_INFRARED_AMBIENT_ENABLE = 5;
	localparam int BIT_AUX_CHANNEL_ENABLE = 6;
	localparam int BIT_UV_INDEX_ENABLE = 7;

	// ---------------------------------------------------------------
	// command codes
	// ---------------------------------------------------------------
	localparam logic [1:0] CMD_NOP = 2'h0;
	localparam logic [1:0] CMD_PARAMETER_READ = 2'h1;
	localparam logic [1:0] CMD_PARAMETER_WRITE = 2'h2;
	localparam logic [1:0] CMD_APPLY_NEW_BUS_ADDRESS = 2'h3;

endpackage

// ==== rtl/spc_sensor_parameter_config.sv ====
`timescale 1ns/100ps

// Behaviour
// [RULE1] parameters reached only via read/write commands
// [RULE2] new bus address applies on apply command
// [RULE3] host sets non-zero channel list first
// [RULE4] bit 7 runs UV index into aux
// [RULE5] bit 6 runs aux channel into aux
// [RULE6] bits 5,4 run infrared and visible channels
// [RULE7] bits 2..0 run proximity 3..1, bit3 reserved
// [RULE8] emitter field is a bitmask per measurement
// [RULE9] ch2 mask bits 6:4, ch1 bits 2:0
// [RULE10] emitter select resets to 0x21
// [RULE11] reserved locations keep their zero defaults; here 0x0D and 0x13 are locked at 0x02 and 0x40
// [RULE12] infrared counter low nibble kept zero
// [RULE13] reserved bits ignored, read as zero
module spc_sensor_parameter_config
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// command port
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_code_i,
	input wire logic [7:0] cmd_offset_i,
	input wire logic [7:0] cmd_wdata_i,
	output logic cmd_done_o,
	output logic [7:0] param_rd_o,
	output logic [7:0] active_bus_addr_o,
	// measurement control
	input wire logic meas_start_i,
	output logic meas_busy_o,
	output logic meas_done_o,
	// converter handshake
	output logic conv_req_o,
	output logic [2:0] conv_chan_o,
	output logic [2:0] emitter_drive_o,
	output logic [7:0] conv_input_sel_o,
	output logic [7:0] conv_counter_o,
	output logic [7:0] conv_gain_o,
	output logic [7:0] conv_misc_o,
	input wire logic conv_done_i,
	input wire logic [15:0] conv_data_i,
	// results
	output logic [15:0] prox1_data_o,
	output logic [15:0] prox2_data_o,
	output logic [15:0] prox3_data_o,
	output logic [15:0] visible_data_o,
	output logic [15:0] infrared_data_o,
	output logic [15:0] aux_data_o
);

	// ---------------------------------------------------------------
	// per-offset attributes
	// ---------------------------------------------------------------
	function automatic logic [7:0] spc_wmask(input logic [4:0] ofs);
		logic [7:0] m;
		m = spc_pkg::MASK_ALL;
		unique case (ofs)
			spc_pkg::OFS_CHANNEL_ENABLE_LIST: m = spc_pkg::MASK_CHANNEL_ENABLE_LIST; // [RULE7]
			spc_pkg::OFS_EMITTER_SELECT_CH12: m = spc_pkg::MASK_EMITTER_SELECT_CH12; // [RULE9]
			spc_pkg::OFS_EMITTER_SELECT_CH3: m = spc_pkg::MASK_EMITTER_SELECT_CH3;
			spc_pkg::OFS_PROX_CONV_COUNTER: m = spc_pkg::MASK_CONV_COUNTER; // [RULE13]
			spc_pkg::OFS_VISIBLE_CONV_COUNTER: m = spc_pkg::MASK_CONV_COUNTER; // [RULE13]
			spc_pkg::OFS_IR_AMBIENT_CONV_COUNTER: m = spc_pkg::MASK_CONV_COUNTER; // [RULE12]
			spc_pkg::OFS_PROX_CONV_GAIN: m = spc_pkg::MASK_CONV_GAIN; // [RULE13]
			spc_pkg::OFS_VISIBLE_CONV_GAIN: m = spc_pkg::MASK_CONV_GAIN; // [RULE13]
			spc_pkg::OFS_IR_AMBIENT_CONV_GAIN: m = spc_pkg::MASK_CONV_GAIN; // [RULE13]
			spc_pkg::OFS_PROX_CONV_MISC: m = spc_pkg::MASK_PROX_CONV_MISC; // [RULE13]
			spc_pkg::OFS_VISIBLE_CONV_MISC: m = spc_pkg::MASK_AMBIENT_CONV_MISC; // [RULE13]
			spc_pkg::OFS_IR_AMBIENT_CONV_MISC: m = spc_pkg::MASK_AMBIENT_CONV_MISC; // [RULE13]
			spc_pkg::OFS_RESERVED_PARAM_0D: m = spc_pkg::MASK_READ_ONLY;
			spc_pkg::OFS_RESERVED_PARAM_13: m = spc_pkg::MASK_READ_ONLY;
			spc_pkg::OFS_RESERVED_PARAM_14: m = spc_pkg::MASK_READ_ONLY; // [RULE11]
			spc_pkg::OFS_RESERVED_PARAM_15: m = spc_pkg::MASK_READ_ONLY; // [RULE11]
			spc_pkg::OFS_RESERVED_PARAM_1B: m = spc_pkg::MASK_READ_ONLY; // [RULE11]
			default: m = spc_pkg::MASK_ALL;
		endcase
		return m;
	endfunction

	function automatic logic [7:0] spc_rstval(input logic [4:0] ofs);
		logic [7:0] v;
		v = spc_pkg::RST_ZERO;
		unique case (ofs)
			spc_pkg::OFS_EMITTER_SELECT_CH12: v = spc_pkg::RST_EMITTER_SELECT_CH12; // [RULE10]
			spc_pkg::OFS_EMITTER_SELECT_CH3: v = spc_pkg::RST_EMITTER_SELECT_CH3;
			spc_pkg::OFS_RESERVED_PARAM_0D: v = spc_pkg::RST_RESERVED_PARAM_0D;
			spc_pkg::OFS_RESERVED_PARAM_13: v = spc_pkg::RST_RESERVED_PARAM_13;
			default: v = spc_pkg::RST_ZERO;
		endcase
		return v;
	endfunction

	// ---------------------------------------------------------------
	// parameter memory
	// ---------------------------------------------------------------
	logic [7:0] param_mem_reg [spc_pkg::PARAM_DEPTH];
	logic [4:0] cmd_ofs;
	logic cmd_in_range;
	logic [7:0] masked_wdata;
	logic cmd_write;

	assign cmd_ofs = cmd_offset_i[4:0];
	assign cmd_in_range = (cmd_offset_i[7:5] == 3'h0);
	assign masked_wdata = cmd_wdata_i & spc_wmask(cmd_ofs);
	// memory has no bus address of its own, only the command path
	assign cmd_write = cmd_valid_i && (cmd_code_i == spc_pkg::CMD_PARAMETER_WRITE)
		&& cmd_in_range; // [RULE1]

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			for (int i = 0; i < spc_pkg::PARAM_DEPTH; i++)
			begin
				param_mem_reg[i] <= spc_rstval(5'(i)); // [RULE10]
			end
		end
		else if (cmd_write)
		begin
			param_mem_reg[cmd_ofs] <= masked_wdata |
				(param_mem_reg[cmd_ofs] & ~spc_wmask(cmd_ofs)); // [RULE13]
		end
	end

	// ---------------------------------------------------------------
	// command answer
	// ---------------------------------------------------------------
	logic [7:0] mem_rd_next;

	always_comb
	begin
		mem_rd_next = spc_pkg::RST_ZERO;
		if (cmd_in_range)
		begin
			if (cmd_code_i == spc_pkg::CMD_PARAMETER_WRITE)
			begin
				mem_rd_next = masked_wdata | (param_mem_reg[cmd_ofs] & ~spc_wmask(cmd_ofs));
			end
			else
			begin
				mem_rd_next = param_mem_reg[cmd_ofs];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			param_rd_o <= spc_pkg::RST_ZERO;
			cmd_done_o <= 1'b0;
		end
		else
		begin
			cmd_done_o <= cmd_valid_i && (cmd_code_i != spc_pkg::CMD_NOP);
			if (cmd_valid_i && (cmd_code_i == spc_pkg::CMD_PARAMETER_READ
				|| cmd_code_i == spc_pkg::CMD_PARAMETER_WRITE))
			begin
				param_rd_o <= mem_rd_next; // [RULE1]
			end
		end
	end

	// ---------------------------------------------------------------
	// bus address
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			active_bus_addr_o <= spc_pkg::RST_ACTIVE_BUS_ADDRESS;
		end
		else if (cmd_valid_i && cmd_code_i == spc_pkg::CMD_APPLY_NEW_BUS_ADDRESS)
		begin
			active_bus_addr_o <= param_mem_reg[spc_pkg::OFS_BUS_ADDRESS_PARAM]; // [RULE2]
		end
	end

	// ---------------------------------------------------------------
	// measurement sequencer
	// ---------------------------------------------------------------
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_PICK = 4'b0010,
		ST_REQ = 4'b0100,
		ST_WAIT = 4'b1000
	} spc_state_t;

	spc_state_t state_reg;
	logic [7:0] pending_reg;
	logic [2:0] chan_reg;
	logic [2:0] pick_chan;
	logic [7:0] channel_enable_list;
	logic [7:0] emit_sel12;
	logic [7:0] emit_sel3;

	assign channel_enable_list = param_mem_reg[spc_pkg::OFS_CHANNEL_ENABLE_LIST];
	assign emit_sel12 = param_mem_reg[spc_pkg::OFS_EMITTER_SELECT_CH12];
	assign emit_sel3 = param_mem_reg[spc_pkg::OFS_EMITTER_SELECT_CH3];

	// lowest pending channel first, so uv index is last to land in aux
	always_comb
	begin
		pick_chan = 3'h0;
		for (int i = 7; i >= 0; i--)
		begin
			if (pending_reg[i])
			begin
				pick_chan = 3'(i);
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_reg <= ST_IDLE;
			pending_reg <= 8'h00;
			chan_reg <= 3'h0;
			meas_done_o <= 1'b0;
			meas_busy_o <= 1'b0;
		end
		else
		begin
			meas_done_o <= 1'b0;
			unique case (state_reg)
				ST_IDLE:
				begin
					if (meas_start_i)
					begin
						// an empty list completes at once with nothing converted
						pending_reg <= channel_enable_list & spc_pkg::MASK_CHANNEL_ENABLE_LIST; // [RULE3]
						meas_busy_o <= 1'b1;
						state_reg <= ST_PICK;
					end
				end
				ST_PICK:
				begin
					if (pending_reg == 8'h00)
					begin
						meas_busy_o <= 1'b0;
						meas_done_o <= 1'b1;
						state_reg <= ST_IDLE;
					end
					else
					begin
						chan_reg <= pick_chan;
						pending_reg[pick_chan] <= 1'b0;
						state_reg <= ST_REQ;
					end
				end
				ST_REQ:
				begin
					state_reg <= ST_WAIT;
				end
				ST_WAIT:
				begin
					if (conv_done_i)
					begin
						state_reg <= ST_PICK;
					end
				end
				default:
				begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// converter request and per-channel settings
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			conv_req_o <= 1'b0;
			conv_chan_o <= 3'h0;
			emitter_drive_o <= 3'h0;
			conv_input_sel_o <= 8'h00;
			conv_counter_o <= 8'h00;
			conv_gain_o <= 8'h00;
			conv_misc_o <= 8'h00;
		end
		else
		begin
			conv_req_o <= (state_reg == ST_REQ);
			if (state_reg == ST_REQ)
			begin
				conv_chan_o <= chan_reg;
				emitter_drive_o <= 3'h0;
				unique case (chan_reg)
					3'(spc_pkg::BIT_PROX_CHANNEL1_ENABLE):
					begin
						emitter_drive_o <= emit_sel12[2:0]; // [RULE8] [RULE9]
						conv_input_sel_o <= param_mem_reg[spc_pkg::OFS_PROX1_INPUT_SELECT];
					end
					3'(spc_pkg::BIT_PROX_CHANNEL2_ENABLE):
					begin
						emitter_drive_o <= emit_sel12[6:4]; // [RULE8] [RULE9]
						conv_input_sel_o <= param_mem_reg[spc_pkg::OFS_PROX2_INPUT_SELECT];
					end
					3'(spc_pkg::BIT_PROX_CHANNEL3_ENABLE):
					begin
						emitter_drive_o <= emit_sel3[2:0]; // [RULE8]
						conv_input_sel_o <= param_mem_reg[spc_pkg::OFS_PROX3_INPUT_SELECT];
					end
					3'(spc_pkg::BIT_INFRARED_AMBIENT_ENABLE):
					begin
						conv_input_sel_o <= param_mem_reg[spc_pkg::OFS_IR_AMBIENT_INPUT_SELECT];
					end
					3'(spc_pkg::BIT_AUX_CHANNEL_ENABLE), 3'(spc_pkg::BIT_UV_INDEX_ENABLE):
					begin
						conv_input_sel_o <= param_mem_reg[spc_pkg::OFS_AUX_INPUT_SELECT];
					end
					default:
					begin
						conv_input_sel_o <= 8'h00;
					end
				endcase
				if (chan_reg <= 3'(spc_pkg::BIT_PROX_CHANNEL3_ENABLE))
				begin
					conv_counter_o <= param_mem_reg[spc_pkg::OFS_PROX_CONV_COUNTER];
					conv_gain_o <= param_mem_reg[spc_pkg::OFS_PROX_CONV_GAIN];
					conv_misc_o <= param_mem_reg[spc_pkg::OFS_PROX_CONV_MISC];
				end
				else if (chan_reg == 3'(spc_pkg::BIT_INFRARED_AMBIENT_ENABLE))
				begin
					conv_counter_o <= param_mem_reg[spc_pkg::OFS_IR_AMBIENT_CONV_COUNTER];
					conv_gain_o <= param_mem_reg[spc_pkg::OFS_IR_AMBIENT_CONV_GAIN];
					conv_misc_o <= param_mem_reg[spc_pkg::OFS_IR_AMBIENT_CONV_MISC];
				end
				else
				begin
					conv_counter_o <= param_mem_reg[spc_pkg::OFS_VISIBLE_CONV_COUNTER];
					conv_gain_o <= param_mem_reg[spc_pkg::OFS_VISIBLE_CONV_GAIN];
					conv_misc_o <= param_mem_reg[spc_pkg::OFS_VISIBLE_CONV_MISC];
				end
			end
			else if (state_reg != ST_WAIT)
			begin
				// emitters only lit while their measurement is in flight
				emitter_drive_o <= 3'h0; // [RULE8]
			end
		end
	end

	// ---------------------------------------------------------------
	// result capture
	// ---------------------------------------------------------------
	logic capture;

	assign capture = (state_reg == ST_WAIT) && conv_done_i;

	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			prox1_data_o <= 16'h0000;
			prox2_data_o <= 16'h0000;
			prox3_data_o <= 16'h0000;
			visible_data_o <= 16'h0000;
			infrared_data_o <= 16'h0000;
			aux_data_o <= 16'h0000;
		end
		else if (capture)
		begin
			unique case (chan_reg)
				3'(spc_pkg::BIT_PROX_CHANNEL1_ENABLE): prox1_data_o <= conv_data_i; // [RULE7]
				3'(spc_pkg::BIT_PROX_CHANNEL2_ENABLE): prox2_data_o <= conv_data_i; // [RULE7]
				3'(spc_pkg::BIT_PROX_CHANNEL3_ENABLE): prox3_data_o <= conv_data_i; // [RULE7]
				3'(spc_pkg::BIT_VISIBLE_AMBIENT_ENABLE): visible_data_o <= conv_data_i; // [RULE6]
				3'(spc_pkg::BIT_INFRARED_AMBIENT_ENABLE): infrared_data_o <= conv_data_i; // [RULE6]
				3'(spc_pkg::BIT_AUX_CHANNEL_ENABLE): aux_data_o <= conv_data_i; // [RULE5]
				3'(spc_pkg::BIT_UV_INDEX_ENABLE): aux_data_o <= conv_data_i; // [RULE4]
				default:
				begin
					aux_data_o <= aux_data_o;
				end
			endcase
		end
	end

endmodule

// ==== verif/spc_config_props.sv ====
`timescale 1ns/100ps
module spc_config_props
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// command port
	input wire logic cmd_valid_i,
	input wire logic [1:0] cmd_code_i,
	input wire logic [7:0] cmd_offset_i,
	input wire logic [7:0] cmd_wdata_i,
	input wire logic cmd_done_o,
	input wire logic [7:0] param_rd_o,
	input wire logic [7:0] active_bus_addr_o,
	// measurement
	input wire logic meas_busy_o,
	input wire logic meas_done_o,
	input wire logic conv_req_o,
	input wire logic [2:0] conv_chan_o,
	input wire logic [2:0] emitter_drive_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);

	a_cmd_done_pulse: assert property (cmd_valid_i && cmd_code_i != 2'h0 |=> cmd_done_o)
		else $error("command without done pulse");
	a_nop_no_done: assert property (cmd_valid_i && cmd_code_i == 2'h0 |=> !cmd_done_o)
		else $error("nop gave a done pulse");
	a_addr_held: assert property (!(cmd_valid_i && cmd_code_i == 2'h3) |=> $stable(active_bus_addr_o))
		else $error("bus address changed without apply");
	a_addr_apply_new: assert property (cmd_valid_i && cmd_code_i == 2'h2 && cmd_offset_i == 8'h00
		##1 !cmd_valid_i ##1 cmd_valid_i && cmd_code_i == 2'h3
		|=> active_bus_addr_o == $past(cmd_wdata_i, 3))
		else $error("applied bus address wrong");
	a_ch12_mask: assert property (cmd_valid_i && cmd_code_i == 2'h2 && cmd_offset_i == 8'h02
		|=> param_rd_o == ($past(cmd_wdata_i) & 8'h77))
		else $error("emitter select write wrong");
	a_channel_enable_list_mask: assert property (cmd_valid_i && cmd_code_i == 2'h2 && cmd_offset_i == 8'h01
		|=> param_rd_o == ($past(cmd_wdata_i) & 8'hF7))
		else $error("channel list write wrong");
	a_rsvd_locked: assert property (cmd_valid_i && cmd_code_i == 2'h2 && cmd_offset_i == 8'h0D
		|=> param_rd_o == 8'h02)
		else $error("reserved location changed");
	a_no_rsvd_chan: assert property (conv_req_o |-> conv_chan_o != 3'h3)
		else $error("reserved channel converted");
	a_no_emit_amb: assert property (conv_req_o && conv_chan_o > 3'h3 |-> emitter_drive_o == 3'h0)
		else $error("emitter driven on ambient channel");
	a_done_ends_busy: assert property (meas_done_o |-> !meas_busy_o && $past(meas_busy_o))
		else $error("done not at end of busy");
endmodule

bind spc_sensor_parameter_config spc_config_props u_props
(
	.ref_clk_i(ref_clk_i),
	.arst_n_i(arst_n_i),
	.cmd_valid_i(cmd_valid_i),
	.cmd_code_i(cmd_code_i),
	.cmd_offset_i(cmd_offset_i),
	.cmd_wdata_i(cmd_wdata_i),
	.cmd_done_o(cmd_done_o),
	.param_rd_o(param_rd_o),
	.active_bus_addr_o(active_bus_addr_o),
	.meas_busy_o(meas_busy_o),
	.meas_done_o(meas_done_o),
	.conv_req_o(conv_req_o),
	.conv_chan_o(conv_chan_o),
	.emitter_drive_o(emitter_drive_o)
);

// ==== verif/spc_conv_model.sv ====
`timescale 1ns/100ps
module spc_conv_model
(
	// clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// converter side
	input wire logic conv_req_i,
	input wire logic [2:0] conv_chan_i,
	input wire logic slow_i,
	output logic conv_done_o,
	output logic [15:0] conv_data_o
);
	logic [3:0] wait_reg;
	logic [2:0] chan_reg;
	logic slow_reg;

	// delay counter, answers only after a request
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			wait_reg <= 4'h0;
		else if (conv_req_i)
			wait_reg <= slow_i ? 4'h6 : 4'h1;
		else if (wait_reg != 4'h0)
			wait_reg <= wait_reg - 4'h1;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (conv_req_i)
		begin
			chan_reg <= conv_chan_i;
			slow_reg <= slow_i;
		end
	end

	// data toggles outside the done cycle
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			conv_done_o <= 1'b0;
			conv_data_o <= 16'h0000;
		end
		else if (wait_reg == 4'h1 && !conv_req_i)
		begin
			conv_done_o <= 1'b1;
			conv_data_o <= {slow_reg ? 4'h5 : 4'hA, 1'b0, chan_reg, 8'h5C};
		end
		else
		begin
			conv_done_o <= 1'b0;
			conv_data_o <= ~conv_data_o;
		end
	end
endmodule

// ==== verif/spc_sensor_parameter_config_test.sv ====
`timescale 1ns/100ps
module spc_sensor_parameter_config_test;
	logic ref_clk_i, arst_n_i, cmd_valid_i, meas_start_i, conv_done_i, slow;
	logic [1:0] cmd_code_i;
	logic [7:0] cmd_offset_i, cmd_wdata_i, param_rd_o, active_bus_addr_o;
	logic cmd_done_o, meas_busy_o, meas_done_o, conv_req_o;
	logic [2:0] conv_chan_o, emitter_drive_o;
	logic [7:0] conv_input_sel_o, conv_counter_o, conv_gain_o, conv_misc_o;
	logic [15:0] conv_data_i, prox1_data_o, prox2_data_o, prox3_data_o;
	logic [15:0] visible_data_o, infrared_data_o, aux_data_o;
	int n_errors = 0;
	int samples_checked = 0;
	logic [37:0] seen_q[$];
	// offset, write data, expected stored value
	logic [23:0] rows[18] = '{24'h02FF77, 24'h01FFF7, 24'h0AF070, 24'h0BFF07, 24'h0CFF24,
		24'h0D5502, 24'h130040, 24'h140000, 24'h150000, 24'h1B0000, 24'h1DF070,
		24'h1FFF20, 24'h1CFFFF, 24'h403900, 24'h0F3C3C, 24'h10A020, 24'h113505,
		24'h1E0202};
	logic [15:0] rst_rows[6] = '{16'h0221, 16'h0304, 16'h0D02, 16'h1340, 16'h0100, 16'h0000};

	spc_sensor_parameter_config DUT (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
		.cmd_valid_i(cmd_valid_i), .cmd_code_i(cmd_code_i), .cmd_offset_i(cmd_offset_i),
		.cmd_wdata_i(cmd_wdata_i), .cmd_done_o(cmd_done_o), .param_rd_o(param_rd_o),
		.active_bus_addr_o(active_bus_addr_o), .meas_start_i(meas_start_i),
		.meas_busy_o(meas_busy_o), .meas_done_o(meas_done_o), .conv_req_o(conv_req_o),
		.conv_chan_o(conv_chan_o), .emitter_drive_o(emitter_drive_o),
		.conv_input_sel_o(conv_input_sel_o), .conv_counter_o(conv_counter_o),
		.conv_gain_o(conv_gain_o), .conv_misc_o(conv_misc_o), .conv_done_i(conv_done_i),
		.conv_data_i(conv_data_i), .prox1_data_o(prox1_data_o), .prox2_data_o(prox2_data_o),
		.prox3_data_o(prox3_data_o), .visible_data_o(visible_data_o),
		.infrared_data_o(infrared_data_o), .aux_data_o(aux_data_o));
	spc_conv_model u_conv (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .conv_req_i(conv_req_o),
		.conv_chan_i(conv_chan_o), .slow_i(slow), .conv_done_o(conv_done_i),
		.conv_data_o(conv_data_i));

	initial
	begin
		ref_clk_i = 1'b0;
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// record channel and emitter mask of each conversion request
	always @(posedge ref_clk_i)
		if (conv_req_o === 1'b1)
			seen_q.push_back({conv_chan_o, emitter_drive_o, conv_input_sel_o, conv_counter_o,
				conv_gain_o, conv_misc_o});

	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic cmd(input logic [1:0] code, input logic [7:0] ofs, input logic [7:0] wd);
		@(posedge ref_clk_i);
		cmd_valid_i <= 1'b1;
		cmd_code_i <= code;
		cmd_offset_i <= ofs;
		cmd_wdata_i <= wd;
		@(posedge ref_clk_i);
		cmd_valid_i <= 1'b0;
		#1;
		check("cmd_done", {15'h0, cmd_done_o}, {15'h0, code != 2'h0});
	endtask

	task automatic do_reset();
		@(posedge ref_clk_i);
		arst_n_i <= 1'b0;
		repeat (7) @(posedge ref_clk_i);
		arst_n_i <= 1'b1;
		#1;
		check("active_addr", {8'h0, active_bus_addr_o}, 16'h005A);
		check("busy", {15'h0, meas_busy_o}, 16'h0000);
		foreach (rst_rows[i])
		begin
			cmd(2'h1, rst_rows[i][15:8], 8'h00);
			check("reset_value", {8'h0, param_rd_o}, {8'h0, rst_rows[i][7:0]});
		end
		$display("test reset done");
	endtask

	function automatic logic [15:0] dat(input logic [2:0] ch, input logic sl);
		return {sl ? 4'h5 : 4'hA, 1'b0, ch, 8'h5C};
	endfunction

	// expected {input select, counter, gain, misc} per channel bit
	function automatic logic [31:0] sets(input int b);
		if (b <= 2)
			return 32'h00700724;
		if (b == 5)
			return 32'h00700220;
		return {(b >= 6) ? 8'h3C : 8'h00, 24'h200500};
	endfunction

	task automatic measure(input logic [7:0] list, input logic sl);
		logic [7:0] eff;
		logic [2:0] em;
		logic [37:0] s;
		logic [31:0] ex;
		int i;
		eff = list & 8'hF7;
		cmd(2'h2, 8'h01, list);
		seen_q.delete();
		@(posedge ref_clk_i);
		meas_start_i <= 1'b1;
		slow <= sl;
		@(posedge ref_clk_i);
		meas_start_i <= 1'b0;
		if (eff != 8'h00)
		begin
			repeat (2) @(posedge ref_clk_i);
			meas_start_i <= 1'b1;
			@(posedge ref_clk_i);
			meas_start_i <= 1'b0;
		end
		i = 0;
		while (meas_done_o !== 1'b1)
		begin
			@(posedge ref_clk_i);
			#1;
			i++;
			if (i > 400)
			begin
				n_errors++;
				print_verdict();
			end
		end
		check("busy_end", {15'h0, meas_busy_o}, 16'h0000);
		repeat (20) @(posedge ref_clk_i);
		check("emitter_idle", {13'h0, emitter_drive_o}, 16'h0000);
		for (int b = 0; b < 8; b++)
		begin
			if (eff[b])
			begin
				em = (b == 0) ? 3'h3 : (b == 1) ? 3'h5 : (b == 2) ? 3'h6 : 3'h0;
				s = seen_q.pop_front();
				ex = sets(b);
				check("conv_order", {10'h0, s[37:32]}, {10'h0, b[2:0], em});
				check("conv_sel_count", s[31:16], ex[31:16]);
				check("conv_gain_misc", s[15:0], ex[15:0]);
			end
		end
		check("extra_convs", seen_q.size(), 16'h0000);
		if (eff[0]) check("prox1", prox1_data_o, dat(3'h0, sl));
		if (eff[1]) check("prox2", prox2_data_o, dat(3'h1, sl));
		if (eff[2]) check("prox3", prox3_data_o, dat(3'h2, sl));
		if (eff[4]) check("visible", visible_data_o, dat(3'h4, sl));
		if (eff[5]) check("infrared", infrared_data_o, dat(3'h5, sl));
		if (eff[7]) check("aux_uv", aux_data_o, dat(3'h7, sl));
		else if (eff[6]) check("aux", aux_data_o, dat(3'h6, sl));
		$display("test measure %h done", list);
	endtask

	initial
	begin
		arst_n_i = 1'b0;
		cmd_valid_i = 1'b0;
		cmd_code_i = 2'h0;
		cmd_offset_i = 8'h00;
		cmd_wdata_i = 8'h00;
		meas_start_i = 1'b0;
		slow = 1'b0;
		do_reset();
		foreach (rows[i])
		begin
			cmd(2'h2, rows[i][23:16], rows[i][15:8]);
			check("write_answer", {8'h0, param_rd_o}, {8'h0, rows[i][7:0]});
			cmd(2'h1, rows[i][23:16], 8'h00);
			check("read_back", {8'h0, param_rd_o}, {8'h0, rows[i][7:0]});
		end
		$display("test table done");
		cmd(2'h0, 8'h02, 8'h00);
		cmd(2'h2, 8'h00, 8'h3C);
		check("addr_kept", {8'h0, active_bus_addr_o}, 16'h005A);
		cmd(2'h3, 8'h00, 8'h00);
		check("addr_applied", {8'h0, active_bus_addr_o}, 16'h003C);
		$display("test bus address done");
		cmd(2'h2, 8'h02, 8'h53);
		cmd(2'h2, 8'h03, 8'h0E);
		measure(8'hFF, 1'b0);
		measure(8'h40, 1'b1);
		measure(8'h08, 1'b0);
		measure(8'h15, 1'b1);
		do_reset();
		print_verdict();
	end
endmodule
